// >>> rtl/dpio_pkg.sv
/*
 * Shared constants and carrier types for the dual parallel I/O port block.
 * Assumes a classic Wishbone slave with 32-bit data, byte addresses and a
 * synchronous active-high reset on a single core clock.
 */
package dpio_pkg;
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DAT_W = 32;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned WIDE_W = 8;
   localparam int unsigned NARROW_W = 4;
   localparam int unsigned NARROW_IO_W = 3;
   localparam int unsigned ONLY_PIN = 3;
   localparam int unsigned SYNC_STAGES = 3;

   // word byte addresses
   localparam logic [ADDR_W-1:0] OFS_EIGHT_PINS = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_EIGHT_DIR = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_EIGHT_LAT = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_EIGHT_ANA = 5'h0C;
   localparam logic [ADDR_W-1:0] OFS_FOUR_PINS = 5'h10;
   localparam logic [ADDR_W-1:0] OFS_FOUR_DIR = 5'h14;
   localparam logic [ADDR_W-1:0] OFS_FOUR_LAT = 5'h18;
   localparam logic [ADDR_W-1:0] OFS_FOUR_ANA = 5'h1C;

   localparam logic [WIDE_W-1:0] RST_EIGHT_DIR = 8'hFF;
   localparam logic [WIDE_W-1:0] RST_EIGHT_ANA = 8'hFF;
   localparam logic [NARROW_IO_W-1:0] RST_FOUR_DIR = 3'h7;
   localparam logic [NARROW_IO_W-1:0] RST_FOUR_ANA = 3'h7;
   localparam logic [NARROW_IO_W-1:0] RST_FOUR_LAT = 3'h0;
   localparam logic [WIDE_W-1:0] RST_EIGHT_LAT = 8'h00;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADDR_W-1:0] adr;
      logic [3:0] sel;
      logic [DAT_W-1:0] dat;
   } dpio_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [DAT_W-1:0] dat;
   } dpio_wb_rsp_t;

   typedef struct packed {
      logic [WIDE_W-1:0] pin_in;
      logic [NARROW_W-1:0] narrow_in;
   } dpio_pins_in_t;

   typedef struct packed {
      logic [WIDE_W-1:0] eight_out;
      logic [WIDE_W-1:0] eight_oe_n;
      logic [NARROW_IO_W-1:0] four_out;
      logic [NARROW_IO_W-1:0] four_oe_n;
      logic [WIDE_W-1:0] eight_ana;
      logic [NARROW_IO_W-1:0] four_ana;
   } dpio_pins_out_t;
endpackage

// >>> rtl/dpio_top.sv
/*
 * Dual parallel I/O port: an eight-bit port and a four-bit port whose top
 * pin is input only, reached over a classic Wishbone slave.
 * Assumes pins are asynchronous to clk_i and that the board resolves the
 * pad level from out/oe_n (oe_n low means driven).
 */
module dpio_top
   import dpio_pkg::*;
#(
   parameter bit HAS_NARROW_IO = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire dpio_pkg::dpio_wb_req_t wb_req_i,
   output dpio_pkg::dpio_wb_rsp_t wb_rsp_o,
   input wire dpio_pkg::dpio_pins_in_t pins_i,
   input wire logic external_reset_pin_select_i,
   output dpio_pkg::dpio_pins_out_t pins_o
);
   import dpio_pkg::*;

   typedef struct packed {
      logic [SYNC_STAGES-1:0][WIDE_W-1:0] eight_sync;
      logic [SYNC_STAGES-1:0][NARROW_W-1:0] four_sync;
      logic [WIDE_W-1:0] eight_pins;
      logic [NARROW_W-1:0] four_pins;
      logic [WIDE_W-1:0] eight_dir;
      logic [WIDE_W-1:0] eight_lat;
      logic [WIDE_W-1:0] eight_ana;
      logic [NARROW_IO_W-1:0] four_dir;
      logic [NARROW_IO_W-1:0] four_lat;
      logic [NARROW_IO_W-1:0] four_ana;
      logic ack;
      logic [DAT_W-1:0] rdat;
   } dpio_state_t;

   dpio_state_t s_q;
   dpio_state_t s_d;
   logic access;
   logic wr_en;
   logic [WIDE_W-1:0] eight_read;
   logic [NARROW_W-1:0] four_read;
   logic [BYTE_W-1:0] wbyte;
   logic [BYTE_W-1:0] rbyte;
   logic [NARROW_IO_W-1:0] io_mask;

   assign io_mask = HAS_NARROW_IO ? {NARROW_IO_W{1'b1}} : '0;
   assign access = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
   // only byte lane 0 carries register data
   assign wr_en = access & wb_req_i.we & wb_req_i.sel[0];
   assign wbyte = wb_req_i.dat[BYTE_W-1:0];

   // analog pins and the reset-selected pin read as zero
   assign eight_read = s_q.eight_pins & ~s_q.eight_ana;
   always_comb begin
      four_read = '0;
      four_read[NARROW_IO_W-1:0] = s_q.four_pins[NARROW_IO_W-1:0] &
         ~s_q.four_ana & io_mask;
      four_read[ONLY_PIN] = s_q.four_pins[ONLY_PIN] &
         ~external_reset_pin_select_i;
   end

   always_comb begin
      rbyte = '0;
      unique case (wb_req_i.adr)
         OFS_EIGHT_PINS: rbyte = eight_read;
         OFS_EIGHT_DIR: rbyte = s_q.eight_dir;
         OFS_EIGHT_LAT: rbyte = s_q.eight_lat;
         OFS_EIGHT_ANA: rbyte = s_q.eight_ana;
         OFS_FOUR_PINS: rbyte = {4'h0, four_read};
         OFS_FOUR_DIR: rbyte = {5'h01, s_q.four_dir & io_mask};
         OFS_FOUR_LAT: rbyte = {5'h00, s_q.four_lat & io_mask};
         OFS_FOUR_ANA: rbyte = {5'h00, s_q.four_ana & io_mask};
         default: rbyte = '0;
      endcase
   end

   always_comb begin
      s_d = s_q;
      // three-stage synchroniser; only stages 1 and 2 are compared
      s_d.eight_sync[0] = pins_i.pin_in;
      s_d.eight_sync[1] = s_q.eight_sync[0];
      s_d.eight_sync[2] = s_q.eight_sync[1];
      s_d.four_sync[0] = pins_i.narrow_in;
      s_d.four_sync[1] = s_q.four_sync[0];
      s_d.four_sync[2] = s_q.four_sync[1];
      for (int i = 0; i < WIDE_W; i++) begin
         if (s_q.eight_sync[1][i] == s_q.eight_sync[2][i]) begin
            s_d.eight_pins[i] = s_q.eight_sync[2][i];
         end
      end
      for (int i = 0; i < NARROW_W; i++) begin
         if (s_q.four_sync[1][i] == s_q.four_sync[2][i]) begin
            s_d.four_pins[i] = s_q.four_sync[2][i];
         end
      end
      s_d.ack = access;
      s_d.rdat = access ? {24'h000000, rbyte} : '0;
      if (wr_en) begin
         unique case (wb_req_i.adr)
            // data writes land in the latch; the whole latch is written,
            // so every latch bit takes the written value, not the pin image
            OFS_EIGHT_PINS: s_d.eight_lat = wbyte;
            OFS_EIGHT_DIR: s_d.eight_dir = wbyte;
            OFS_EIGHT_LAT: s_d.eight_lat = wbyte;
            OFS_EIGHT_ANA: s_d.eight_ana = wbyte;
            OFS_FOUR_PINS:
               s_d.four_lat = wbyte[NARROW_IO_W-1:0];
            OFS_FOUR_DIR: s_d.four_dir = wbyte[NARROW_IO_W-1:0];
            OFS_FOUR_LAT: s_d.four_lat = wbyte[NARROW_IO_W-1:0];
            OFS_FOUR_ANA: s_d.four_ana = wbyte[NARROW_IO_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         // latches are not cleared by reset; they hold, or take a write made during reset, as on a warm reset
         s_q.eight_sync <= '0;
         s_q.four_sync <= '0;
         s_q.eight_pins <= '0;
         s_q.four_pins <= '0;
         s_q.eight_dir <= RST_EIGHT_DIR;
         s_q.eight_ana <= RST_EIGHT_ANA;
         s_q.four_dir <= RST_FOUR_DIR;
         s_q.four_ana <= RST_FOUR_ANA;
         s_q.eight_lat <= s_d.eight_lat;
         s_q.four_lat <= s_d.four_lat;
         s_q.ack <= 1'b0;
         s_q.rdat <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // pin drive ignores analog select; no other source exists
   always_comb begin
      pins_o.eight_out = s_q.eight_lat;
      pins_o.eight_oe_n = s_q.eight_dir;
      pins_o.four_out = s_q.four_lat & io_mask;
      pins_o.four_oe_n = s_q.four_dir | ~io_mask;
      pins_o.eight_ana = s_q.eight_ana;
      pins_o.four_ana = s_q.four_ana & io_mask;
   end

   assign wb_rsp_o.ack = s_q.ack;
   assign wb_rsp_o.dat = s_q.rdat;
endmodule // dpio_top

// >>> verification/dpio_board.sv
/* board at the pads; pad follows driver when oe_n low, else board level */
module dpio_board
   import dpio_pkg::*;
(
   input wire dpio_pkg::dpio_pins_out_t pins_o,
   input wire logic [7:0] eight_ext_i,
   input wire logic [3:0] four_ext_i,
   output dpio_pkg::dpio_pins_in_t pins_i
);
   timeunit 1ns;
   timeprecision 1ps;
   // input-only pin is always the board's level
   assign pins_i = '{pin_in: (pins_o.eight_oe_n & eight_ext_i) |
      (~pins_o.eight_oe_n & pins_o.eight_out), narrow_in: {four_ext_i[3],
      (pins_o.four_oe_n & four_ext_i[2:0]) | (~pins_o.four_oe_n & pins_o.four_out)}};
endmodule // dpio_board

// >>> verification/dpio_chk.sv
/* port checker; bound to dpio_top, one clock */
module dpio_chk
   import dpio_pkg::*;
#(
   parameter bit HAS_NARROW_IO = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire dpio_pkg::dpio_wb_req_t wb_req_i,
   input wire dpio_pkg::dpio_wb_rsp_t wb_rsp_o,
   input wire dpio_pkg::dpio_pins_in_t pins_i,
   input wire logic external_reset_pin_select_i,
   input wire dpio_pkg::dpio_pins_out_t pins_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic tk, wr0, rd0;
   logic [4:0] a;
   assign tk = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
   assign wr0 = tk & wb_req_i.we & wb_req_i.sel[0];
   assign rd0 = tk & ~wb_req_i.we;
   assign a = wb_req_i.adr;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_next: assert property (
      tk |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
      else $error("ack not a one-cycle answer");
   a_dir_reset: assert property (
      $fell(rst_i) |-> pins_o.eight_oe_n == 8'hFF
      && pins_o.eight_ana == 8'hFF) else $error("reset state wrong");
   a_dir_drive: assert property (
      wr0 && a == OFS_EIGHT_DIR
      |=> pins_o.eight_oe_n == $past(wb_req_i.dat[7:0]))
      else $error("oe wrong");
   a_data_latch: assert property (
      wr0 && a == OFS_EIGHT_PINS
      |=> pins_o.eight_out == $past(wb_req_i.dat[7:0]))
      else $error("out wrong");
   a_ana_reads: assert property (
      rd0 && a == OFS_EIGHT_PINS
      |=> (wb_rsp_o.dat[7:0] & pins_o.eight_ana) == 8'h00)
      else $error("ana rd");
   a_ana_out: assert property (
      wr0 && a == OFS_EIGHT_ANA |=> $stable(pins_o.eight_out))
      else $error("analog moved output");
   a_top_zero: assert property (
      wb_rsp_o.ack |-> wb_rsp_o.dat[31:8] == 24'h0)
      else $error("upper read bits set");
   a_only_zero: assert property (
      rd0 && a == OFS_FOUR_PINS && external_reset_pin_select_i
      |=> !wb_rsp_o.dat[3]) else $error("pin3");
   a_four_dir: assert property (
      rd0 && a == OFS_FOUR_DIR |=> wb_rsp_o.dat[7:3] == 5'h01)
      else $error("four dir upper bits");
   c_dir: cover property (wr0 && a == OFS_EIGHT_DIR);
   c_pin3: cover property (rd0 && a == OFS_FOUR_PINS
      && external_reset_pin_select_i);
   c_ana: cover property (wr0 && a == OFS_EIGHT_ANA);
endmodule // dpio_chk

// >>> verification/dual_parallel_io_port_test.sv
/* register-level test of dpio_top; board model drives the pads */
module dual_parallel_io_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import dpio_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, sel_i = 1'b0;
   dpio_wb_req_t req = '0;
   dpio_wb_rsp_t rsp;
   dpio_pins_in_t pins;
   dpio_pins_out_t pout;
   logic [7:0] ext8 = 8'hC3;
   logic [3:0] ext4 = 4'h8;
   int err_count = 0, checked = 0;
   dpio_top dut(.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
      .pins_i(pins), .external_reset_pin_select_i(sel_i), .pins_o(pout));
   dpio_board board(.pins_o(pout), .eight_ext_i(ext8), .four_ext_i(ext4),
      .pins_i(pins));
   initial forever #5 clk_i = ~clk_i;
   task automatic conclude();
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // request held until the rising edge that samples ack high
   task automatic xfer(input logic w, logic [4:0] a, logic [3:0] s,
      logic [7:0] d, output logic [31:0] q);
      req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: s, dat: {24'h0, d}};
      do @(posedge clk_i); while (rsp.ack !== 1'b1);
      q = rsp.dat;
      req <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [4:0] a, logic [7:0] d, logic [3:0] s);
      logic [31:0] q;
      xfer(1'b1, a, s, d, q);
   endtask
   task automatic rd(input logic [4:0] a, logic [7:0] e);
      logic [31:0] q;
      xfer(1'b0, a, 4'h1, 8'h00, q);
      chk($sformatf("reg %h", a), q, {24'h0, e});
   endtask
   initial begin
      repeat (5000) @(posedge clk_i);
      err_count++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFS_EIGHT_DIR, 8'hFF);
      rd(OFS_EIGHT_ANA, 8'hFF);
      rd(OFS_FOUR_DIR, 8'h0F);
      rd(OFS_FOUR_ANA, 8'h07);
      rd(OFS_EIGHT_PINS, 8'h00);
      wr(OFS_EIGHT_PINS, 8'h5A, 4'h1);
      wr(OFS_EIGHT_DIR, 8'h00, 4'h1);
      chk("eight_out", pout.eight_out, 8'h5A);
      wr(OFS_EIGHT_DIR, 8'hFF, 4'hE);
      chk("eight_oe_n", pout.eight_oe_n, 8'h00);
      rd(OFS_EIGHT_LAT, 8'h5A);
      wr(OFS_EIGHT_ANA, 8'h0F, 4'h1);
      chk("eight_ana", pout.eight_ana, 8'h0F);
      repeat (6) @(posedge clk_i);
      rd(OFS_EIGHT_PINS, 8'h50);
      wr(OFS_EIGHT_DIR, 8'hFF, 4'h1);
      wr(OFS_EIGHT_ANA, 8'h00, 4'h1);
      repeat (6) @(posedge clk_i);
      rd(OFS_EIGHT_PINS, 8'hC3);
      wr(OFS_FOUR_LAT, 8'hFF, 4'h1);
      rd(OFS_FOUR_LAT, 8'h07);
      wr(OFS_FOUR_DIR, 8'h00, 4'h1);
      rd(OFS_FOUR_DIR, 8'h08);
      wr(OFS_FOUR_ANA, 8'h00, 4'h1);
      wr(OFS_FOUR_PINS, 8'h02, 4'h1);
      repeat (6) @(posedge clk_i);
      rd(OFS_FOUR_PINS, 8'h0A);
      chk("four_out", pout.four_out, 3'h2);
      chk("four_oe_n", pout.four_oe_n, 3'h0);
      sel_i <= 1'b1;
      @(posedge clk_i);
      rd(OFS_FOUR_PINS, 8'h02);
      wr(OFS_FOUR_ANA, 8'h02, 4'h1);
      chk("four_ana", pout.four_ana, 3'h2);
      rd(OFS_FOUR_PINS, 8'h00);
      wr(5'h01, 8'h00, 4'h1);
      rd(5'h01, 8'h00);
      rst_i <= 1'b1;
      @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(OFS_EIGHT_LAT, 8'h5A);
      rd(OFS_EIGHT_DIR, 8'hFF);
      conclude();
   end
endmodule // dual_parallel_io_port_test
bind dpio_top dpio_chk #(.HAS_NARROW_IO(HAS_NARROW_IO)) u_chk(.clk_i(clk_i),
   .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pins_i(pins_i),
   .external_reset_pin_select_i(external_reset_pin_select_i), .pins_o(pins_o));
